// ===== hw/tsl_defs.svh
// Summary of operation
// [R1] Serial-input register is byte wide, write only; bit 0 shifts into chain.
// [R2] Bits 7 to 1 of a serial-input write are ignored.
// [R3] Software makes exactly fifty-six serial writes to fill the pattern.
// [R4] A load-strobe write copies the whole chain into the control register.
// [R5] Software strobes only after all fifty-six bits are shifted in.
// [R6] Load strobe has no data bits; any written value triggers the copy.
// [R7] Active pattern routes trigger lines to and from request/acknowledge lines.
// [R8] Serial input sits at offset 0x10, load strobe at 0x12, 8-bit writes.
`ifndef TSL_DEFS_SVH
`define TSL_DEFS_SVH
`define TSL_OFF_SERIAL_IN  5'h10
`define TSL_OFF_LOAD_STRB  5'h12
`define TSL_OFF_STATUS     5'h14
`define TSL_SERIAL_BIT     0
`define TSL_CHAIN_BITS     56
`define TSL_N_LINES        7
`define TSL_N_SIG          4
`define TSL_LINE_CFG_W     8
`define TSL_CFG_SRC_LSB    0
`define TSL_CFG_OE_BIT     2
`define TSL_CFG_SINK_LSB   4
`define TSL_STAT_FULL_BIT  7
`define TSL_PATTERN_RST    56'h00000000000000
`define TSL_RDATA_RST      8'h00
`endif

// ===== hw/tsl_pkg.sv
`include "tsl_defs.svh"
package tsl_pkg;
  typedef logic [`TSL_CHAIN_BITS-1:0] tsl_pattern_t;
  typedef logic [7:0]                 tsl_byte_t;
  typedef logic [6:0]                 tsl_count_t;
endpackage : tsl_pkg

// ===== hw/tsl_route_matrix.sv
`timescale 1ns/1ns
`default_nettype none
`include "tsl_defs.svh"
module tsl_route_matrix #(
  parameter int N_LINES = `TSL_N_LINES,
  parameter int N_SIG   = `TSL_N_SIG
) (
  input  wire logic                          clk_sys,
  input  wire logic                          arst_n,
  input  wire logic [N_LINES*`TSL_LINE_CFG_W-1:0] pattern,
  input  wire logic [N_SIG-1:0]              board_sig_out,
  input  wire logic [N_LINES-1:0]            trig_in,
  output logic      [N_LINES-1:0]            trig_out,
  output logic      [N_LINES-1:0]            trig_oe,
  output logic      [N_SIG-1:0]              board_sig_in
);
  logic [N_SIG-1:0][N_LINES-1:0] hit;
  logic [N_LINES-1:0]            drv_nxt;
  logic [N_LINES-1:0]            oe_nxt;
  logic [N_SIG-1:0]              sink_nxt;
  logic [N_LINES-1:0]            drv_r;
  logic [N_LINES-1:0]            oe_r;
  logic [N_SIG-1:0]              sink_r;

  if (N_SIG != 4) $error("tsl_route_matrix: N_SIG must be 4");

  // Per trigger line: source select, drive enable, sink enables
  for (genvar i = 0; i < N_LINES; i++)
  begin : g_line
    wire logic [`TSL_LINE_CFG_W-1:0] cfg = pattern[i*`TSL_LINE_CFG_W +: `TSL_LINE_CFG_W];
    assign drv_nxt[i] = board_sig_out[cfg[`TSL_CFG_SRC_LSB +: 2]]; // [R7]
    assign oe_nxt[i]  = cfg[`TSL_CFG_OE_BIT]; // [R7]
    for (genvar j = 0; j < N_SIG; j++)
    begin : g_sink
      assign hit[j][i] = cfg[`TSL_CFG_SINK_LSB+j] & trig_in[i]; // [R7]
    end
  end
  for (genvar j = 0; j < N_SIG; j++)
  begin : g_sig
    assign sink_nxt[j] = |hit[j];
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      drv_r  <= '0;
      oe_r   <= '0;
      sink_r <= '0;
    end
    else
    begin
      drv_r  <= drv_nxt;
      oe_r   <= oe_nxt;
      sink_r <= sink_nxt;
    end
  end

  assign trig_out     = drv_r;
  assign trig_oe      = oe_r;
  assign board_sig_in = sink_r;
endmodule : tsl_route_matrix
`default_nettype wire

// ===== hw/tsl_trigger_switch_loader.sv
// Design decision made here: the strobed register port.
`timescale 1ns/1ns
`default_nettype none
`include "tsl_defs.svh"
module tsl_trigger_switch_loader #(
  parameter int CHAIN_BITS = `TSL_CHAIN_BITS,
  parameter int N_LINES    = `TSL_N_LINES,
  parameter int N_SIG      = `TSL_N_SIG
) (
  input  wire logic                  clk_sys,
  input  wire logic                  arst_n,
  input  wire logic [4:0]            reg_addr,
  input  wire logic [7:0]            reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [7:0]            reg_rdata,
  input  wire logic [N_SIG-1:0]      board_sig_out,
  output logic      [N_SIG-1:0]      board_sig_in,
  input  wire logic [N_LINES-1:0]    trig_in,
  output logic      [N_LINES-1:0]    trig_out,
  output logic      [N_LINES-1:0]    trig_oe
);
  if (CHAIN_BITS != N_LINES * `TSL_LINE_CFG_W)
    $error("tsl_trigger_switch_loader: CHAIN_BITS must be N_LINES*8");
  if (CHAIN_BITS < 2 || CHAIN_BITS > 127)
    $error("tsl_trigger_switch_loader: CHAIN_BITS out of range");
  if (N_SIG != 4)
    $error("tsl_trigger_switch_loader: N_SIG must be 4");
  if (N_LINES < 1)
    $error("tsl_trigger_switch_loader: N_LINES must be at least 1");

  localparam tsl_pkg::tsl_count_t CHAIN_CNT = 7'(CHAIN_BITS);

  logic [CHAIN_BITS-1:0] shift_r;
  logic [CHAIN_BITS-1:0] shift_nxt;
  logic [CHAIN_BITS-1:0] ctrl_r;
  logic [CHAIN_BITS-1:0] ctrl_nxt;
  tsl_pkg::tsl_count_t   cnt_r;
  tsl_pkg::tsl_count_t   cnt_nxt;
  tsl_pkg::tsl_byte_t    rdata_r;
  tsl_pkg::tsl_byte_t    rdata_nxt;
  tsl_pkg::tsl_byte_t    status_byte;
  logic                  hit_ser;
  logic                  hit_strb;
  logic                  hit_stat;
  logic                  full;

  // Address decode
  assign hit_ser  = reg_wr && (reg_addr == `TSL_OFF_SERIAL_IN); // [R8]
  assign hit_strb = reg_wr && (reg_addr == `TSL_OFF_LOAD_STRB); // [R8] [R6]
  assign hit_stat = reg_rd && (reg_addr == `TSL_OFF_STATUS);

  // Shift chain takes only bit 0 of the written byte
  assign shift_nxt = hit_ser ? {shift_r[CHAIN_BITS-2:0], reg_wdata[`TSL_SERIAL_BIT]} // [R1] [R2]
                             : shift_r;

  // Whole chain copied in one step, data byte ignored
  assign ctrl_nxt = hit_strb ? shift_r : ctrl_r; // [R4] [R6]

  // Bits shifted since last strobe, saturating at a full pattern
  assign full    = (cnt_r == CHAIN_CNT); // [R3] [R5]
  assign cnt_nxt = hit_strb               ? 7'h00 :
                   (hit_ser && !full)     ? 7'(cnt_r + 7'h01) :
                   cnt_r;

  assign status_byte = {full, cnt_r};

  // Write-only locations and unmapped reads answer zero
  assign rdata_nxt = hit_stat ? status_byte : `TSL_RDATA_RST;

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      shift_r <= CHAIN_BITS'(`TSL_PATTERN_RST);
      ctrl_r  <= CHAIN_BITS'(`TSL_PATTERN_RST);
      cnt_r   <= 7'h00;
      rdata_r <= `TSL_RDATA_RST;
    end
    else
    begin
      shift_r <= shift_nxt;
      ctrl_r  <= ctrl_nxt;
      cnt_r   <= cnt_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

  // Routing of the active pattern
  tsl_route_matrix #(
    .N_LINES (N_LINES),
    .N_SIG   (N_SIG)
  ) u_route (
    .clk_sys       (clk_sys),
    .arst_n        (arst_n),
    .pattern       (ctrl_r),
    .board_sig_out (board_sig_out),
    .trig_in       (trig_in),
    .trig_out      (trig_out),
    .trig_oe       (trig_oe),
    .board_sig_in  (board_sig_in)
  );

  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  sequence s_serial_write;
    hit_ser;
  endsequence

  sequence s_strobe_write;
    hit_strb;
  endsequence

  sequence s_load_then_route;
    hit_strb ##1 (ctrl_r == $past(shift_r));
  endsequence

  // Steps of counting and read-back
  sequence s_shift_counted;
    hit_ser && !full;
  endsequence

  sequence s_full_pattern;
    full && !hit_strb;
  endsequence

  sequence s_status_read;
    hit_stat;
  endsequence

  AST_SHIFT_IN: assert property ( // [R1]
    s_serial_write |=> (shift_r[0] == $past(reg_wdata[0]))
                       && (shift_r[CHAIN_BITS-1:1] == $past(shift_r[CHAIN_BITS-2:0])))
    else $error("serial write did not shift bit 0 into the chain");

  AST_UPPER_IGNORED: assert property ( // [R2]
    (s_serial_write and (reg_wdata[0] == 1'b0)) |=> (shift_r[0] == 1'b0))
    else $error("upper data bits reached the shift chain");

  AST_FULL_COUNT: assert property ( // [R3]
    (hit_ser && (cnt_r == 7'(CHAIN_BITS - 1))) |=> full ##1 (reg_rdata[7] || !$past(hit_stat)))
    else $error("pattern not reported full after the last serial write");

  AST_LOAD: assert property ( // [R4]
    s_strobe_write |=> (ctrl_r == $past(shift_r)) && (cnt_r == 7'h00))
    else $error("load strobe did not copy the chain");

  AST_HOLD: assert property ( // [R4]
    !hit_strb |=> $stable(ctrl_r))
    else $error("control register changed without a load strobe");

  AST_ANY_DATA: assert property ( // [R6]
    (s_strobe_write and (reg_wdata == 8'h00)) |=> (ctrl_r == $past(shift_r)))
    else $error("load strobe depended on written data");

  AST_ROUTE_OE: assert property ( // [R7]
    s_load_then_route |=> (trig_oe[0] == $past(ctrl_r[`TSL_CFG_OE_BIT])))
    else $error("drive enable does not follow the active pattern");

  AST_ROUTE_SINK: assert property ( // [R7]
    (ctrl_r[(N_LINES-1)*`TSL_LINE_CFG_W+`TSL_CFG_SINK_LSB] && trig_in[N_LINES-1]) |=> board_sig_in[0])
    else $error("last trigger line not routed to board signal");

  AST_SINK_ROUTE: assert property ( // [R7]
    (ctrl_r[`TSL_CFG_SINK_LSB] && trig_in[0]) |=> board_sig_in[0])
    else $error("trigger line not routed to board signal");

  AST_DECODE: assert property ( // [R8]
    (reg_wr && (reg_addr != `TSL_OFF_SERIAL_IN)) |=> $stable(shift_r))
    else $error("chain moved on a write to another offset");

  AST_RDATA_ZERO: assert property ( // [R8]
    (reg_rd && (reg_addr != `TSL_OFF_STATUS)) |=> (reg_rdata == 8'h00))
    else $error("write-only or unmapped read returned data");

  AST_RDATA_ONE_CYCLE: assert property ( // [R8]
    hit_stat ##1 !reg_rd |=> (reg_rdata == 8'h00))
    else $error("read data stood longer than one cycle");

  // Counting, read-back, strobe keeping the chain, and quiet sinks
  AST_COUNT_STEP: assert property ( // [R3]
    s_shift_counted |=> (cnt_r == 7'($past(cnt_r) + 7'h01)))
    else $error("serial write was not counted");

  AST_COUNT_SAT: assert property ( // [R3]
    s_full_pattern |=> full)
    else $error("full pattern count did not saturate");

  AST_COUNT_LIMIT: assert property ( // [R3]
    (cnt_r <= CHAIN_CNT))
    else $error("shift count passed the pattern length");

  AST_STATUS_READ: assert property ( // [R8]
    s_status_read |=> (reg_rdata == {$past(full), $past(cnt_r)}))
    else $error("status read returned the wrong count");

  AST_IDLE_RDATA: assert property ( // [R8]
    !reg_rd |=> (reg_rdata == 8'h00))
    else $error("read data shown without a read strobe");

  AST_STRB_KEEPS_CHAIN: assert property ( // [R4]
    s_strobe_write |=> $stable(shift_r))
    else $error("load strobe disturbed the shift chain");

  AST_SINK_QUIET: assert property ( // [R7]
    (trig_in == '0) |=> (board_sig_in == '0))
    else $error("board signal raised with every trigger line low");

  // Per trigger line: drive level and enable follow the active pattern
  for (genvar i = 0; i < N_LINES; i++)
  begin : g_route_chk
    AST_ROUTE_DRIVE: assert property ( // [R7]
      1'b1 |=> (trig_out[i] == $past(board_sig_out[ctrl_r[i*`TSL_LINE_CFG_W +: 2]])))
      else $error("trigger line drive does not follow the active pattern");

    AST_ROUTE_ENABLE: assert property ( // [R7]
      1'b1 |=> (trig_oe[i] == $past(ctrl_r[i*`TSL_LINE_CFG_W + `TSL_CFG_OE_BIT])))
      else $error("trigger line enable does not follow the active pattern");
  end
endmodule : tsl_trigger_switch_loader
`default_nettype wire

// ===== verification/tsl_trig_peer.sv
`timescale 1ns/1ns
`default_nettype none
module tsl_trig_peer (
  input  wire logic [6:0] peer_lvl,
  input  wire logic [6:0] trig_out,
  input  wire logic [6:0] trig_oe,
  output logic      [6:0] trig_in
);
  // Other boards drive every line this board leaves
  assign trig_in = (trig_oe & trig_out) | (~trig_oe & peer_lvl);
endmodule : tsl_trig_peer
`default_nettype wire

// ===== verification/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic        clk_sys       = 1'b0;
  logic        arst_n        = 1'b0;
  logic [4:0]  reg_addr      = 5'h00;
  logic [7:0]  reg_wdata     = 8'h00;
  logic        reg_wr        = 1'b0;
  logic        reg_rd        = 1'b0;
  logic [3:0]  board_sig_out = 4'h0;
  logic [6:0]  peer_lvl      = 7'h00;
  logic        rd_d          = 1'b0;
  logic        route_chk     = 1'b0;
  logic [7:0]  reg_rdata;
  logic [3:0]  board_sig_in;
  logic [6:0]  trig_in, trig_out, trig_oe;
  logic [55:0] pat;
  logic [31:0] exp_q[$];
  int          fails = 0;
  int          samples_checked = 0;
  always #5 clk_sys = ~clk_sys;
  tsl_trigger_switch_loader tsl_trigger_switch_loader_i (.clk_sys, .arst_n, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .board_sig_out, .board_sig_in, .trig_in,
    .trig_out, .trig_oe);
  tsl_trig_peer tsl_trig_peer_i (.peer_lvl, .trig_out, .trig_oe, .trig_in);
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want)
    begin
      fails++;
      $display("mismatch t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check
  task automatic close_out;
    $display("compared %0d mismatched %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  task automatic bus(input logic w, input logic r, input logic [4:0] a, input logic [7:0] d);
    reg_wr    <= w;
    reg_rd    <= r;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
  endtask : bus
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    bus(1'b0, 1'b1, a, 8'h00);
  endtask : rd
  function automatic logic [31:0] route_exp(input logic [55:0] p, input logic [3:0] s,
                                            input logic [6:0] l);
    logic [6:0] o, e, ln;
    logic [3:0] b;
    b = 4'h0;
    for (int i = 0; i < 7; i++)
    begin
      e[i]  = p[8*i+2];
      o[i]  = s[p[8*i +: 2]];
      ln[i] = e[i] ? o[i] : l[i];
      b     = b | (p[8*i+4 +: 4] & {4{ln[i]}});
    end
    return {14'h0, b, e, o & e};
  endfunction : route_exp
  // Monitor takes the oldest note whenever a result is due
  always @(posedge clk_sys) rd_d <= reg_rd;
  always @(negedge clk_sys)
  begin
    if (rd_d || route_chk)
    begin
      if (exp_q.size() == 0)
        check(32'hffffffff, 32'h0);
      else if (rd_d)
        check({24'h0, reg_rdata}, exp_q.pop_front());
      else
        check({14'h0, board_sig_in, trig_oe, trig_out & trig_oe}, exp_q.pop_front());
    end
  end
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    close_out();
  end
  initial
  begin
    void'($urandom(78852));
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'b1;
    rd(5'h14, 8'h00);
    bus(1'b0, 1'b0, 5'h00, 8'h00);
    $display("test reset done");
    for (int k = 0; k < 3; k++)
    begin
      pat = {24'($urandom), 32'($urandom)};
      // Fifty-six bits, last bit written lands at bit 0; one stray write mid-way
      for (int n = 55; n >= 0; n--)
      begin
        bus(1'b1, 1'b0, 5'h10, {7'($urandom), pat[n]});
        if (n == 20)
          bus(1'b1, 1'b0, 5'h11, 8'($urandom));
      end
      rd(5'h14, 8'hb8);
      rd(5'h10, 8'h00);
      rd(5'h12, 8'h00);
      rd(5'h1f, 8'h00);
      bus(1'b1, 1'b0, 5'h12, (k == 0) ? 8'h00 : 8'($urandom));
      rd(5'h14, 8'h00);
      bus(1'b0, 1'b0, 5'h00, 8'h00);
      repeat (4)
      begin
        board_sig_out <= 4'($urandom);
        peer_lvl      <= 7'($urandom);
        repeat (3) @(posedge clk_sys);
        exp_q.push_back(route_exp(pat, board_sig_out, peer_lvl));
        route_chk <= 1'b1;
        @(posedge clk_sys);
        route_chk <= 1'b0;
      end
      $display("test pattern %0d done", k);
    end
    repeat (2) @(posedge clk_sys);
    check(32'(exp_q.size()), 32'h0);
    close_out();
  end
endmodule : testbench
`default_nettype wire
